// ### include/scs_pkg.sv
package scs_pkg;

	// register addresses on the special-function-register port
	localparam logic [7:0] SCS_CLK_SEL_ADDR = 8'h8F;
	localparam logic [7:0] SCS_OSC_CTRL_ADDR = 8'hA1;

	// clock select register fields
	localparam int SCS_SEL_LSB = 0;
	localparam int SCS_SEL_MSB = 1;
	localparam logic [1:0] SCS_SEL_RESET = 2'h0;

	// oscillator control register fields
	localparam int SCS_EN_LSB = 6;
	localparam int SCS_EN_MSB = 7;
	localparam int SCS_SUSP_BIT = 5;
	localparam int SCS_RDY_BIT = 4;
	localparam int SCS_RSVD_BIT = 3;
	localparam int SCS_DIV_LSB = 0;
	localparam int SCS_DIV_MSB = 2;
	localparam logic [1:0] SCS_EN_ON = 2'h3;
	localparam logic [1:0] SCS_EN_RESET = 2'h3;
	localparam logic [2:0] SCS_DIV_RESET = 3'h0;
	localparam logic SCS_SUSP_RESET = 1'b0;
	localparam logic SCS_RDY_RESET = 1'b1;
	localparam logic [7:0] SCS_RD_ZERO = 8'h00;

	// divider: code 000 divides by 128, 111 by 1
	localparam int SCS_DIV_CNT_W = 7;
	localparam logic [6:0] SCS_DIV_MAX_PERIOD = 7'h7F;

	// timing
	localparam int SCS_SYS_CLK_MHZ = 125;
	localparam int SCS_OSC_BASE_MHZ = 24;
	localparam int SCS_OSC_SETTLE_NS = 2000;
	localparam int SCS_OSC_SETTLE_CYC =
		(SCS_OSC_SETTLE_NS * SCS_SYS_CLK_MHZ + 999) / 1000;
	localparam int SCS_SETTLE_W = 9;

	// oscillator phase accumulator width
	localparam int SCS_NCO_W = 16;

	typedef enum logic [1:0] {
		SCS_SRC_INT_OSC = 2'h0,
		SCS_SRC_EXT_OSC = 2'h1,
		SCS_SRC_MULT = 2'h2,
		SCS_SRC_RSVD = 2'h3
	} scs_src_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scs_sfr_req_s;

	typedef struct packed {
		logic [3:0] port_match;
		logic cmp0_enable;
		logic cmp0_out;
	} scs_wake_s;

	typedef struct packed {
		logic [6:0] coarse;
		logic [5:0] fine;
	} scs_trim_s;

endpackage

// ### design/scs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic [WIDTH-1:0] async_in, // foreign-domain levels
	output logic [WIDTH-1:0] sync_out // levels safe to use
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read by the second stage only
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### design/scs_div.sv
`timescale 1ns/1ps
`default_nettype none
module scs_div
	import scs_pkg::*;
#(
	parameter int CODE_W = 3
) (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic osc_tick, // one pulse per oscillator period
	input wire logic [CODE_W-1:0] osc_divide_select, // divider code
	output logic div_tick // one pulse per divided period
);
	logic [SCS_DIV_CNT_W-1:0] cnt_q;
	logic [CODE_W-1:0] code_q;
	logic [SCS_DIV_CNT_W-1:0] last;

	// 000 -> 127, 111 -> 0
	assign last = SCS_DIV_MAX_PERIOD >> code_q;

	// new code is taken only at a period boundary, so no short pulse
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cnt_q <= '0;
			code_q <= SCS_DIV_RESET;
			div_tick <= 1'b0;
		end else begin
			div_tick <= 1'b0;
			if (osc_tick) begin
				if (cnt_q >= last) begin
					cnt_q <= '0;
					div_tick <= 1'b1;
					code_q <= osc_divide_select;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### design/scs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - selector 00: clock is internal oscillator through its divider
// - selector 01: system clock follows the external oscillator
// - selector 10: system clock follows the multiplier; 11 is reserved
// - clock select bits 7:2 read zero and ignore writes
// - reset selects the internal oscillator, selector field zero
// - divider codes 000..111 divide by 128 down to 1
// - divider resets to divide-by-128
// - coarse and fine trim set the oscillator period, 24 MHz nominal
// - enable field 11 runs oscillator except in suspend; 00 stops it
// - writing one to bit 5 suspends the internal oscillator
// - suspended on internal oscillator: core and peripheral clock gated
// - wake on port 0..3 match or comparator 0 enabled with low output
// - wake restarts oscillator, core and peripherals, interrupt or not
// - processor resumes at the instruction after the suspend write
// - ready flag at bit 4 reads one when oscillator runs as programmed
// - bit 3 is reserved, reads zero, software writes zero
module scs_ctrl
	import scs_pkg::*;
#(
	parameter int SETTLE_CYC = SCS_OSC_SETTLE_CYC
) (
	input wire logic sys_clk, // system clock, 125 MHz
	input wire logic nrst, // sync reset, active low
	input wire scs_sfr_req_s sfr_req, // register port request
	output logic [7:0] sfr_rdata, // register read data
	input wire scs_trim_s osc_trim, // factory trim values
	input wire logic ext_osc_clk, // external oscillator level, async
	input wire logic mult_tick, // multiplier clock pulse
	input wire scs_wake_s wake_in, // wake sources, async
	output logic system_clock_out, // selected clock pulse
	output logic cpu_clk_en, // processor/peripheral clock pulse
	output logic osc_running, // internal oscillator active
	output logic osc_freq_ready_flag, // oscillator settled
	output logic osc_suspended, // suspend mode in force
	output logic wake_pulse, // one cycle on wake
	output logic [1:0] clock_source_active // source now driving clock
);
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SUSPEND,
		ST_WAKE
	} scs_susp_e;

	typedef enum logic {
		SW_IDLE,
		SW_DRAIN
	} scs_sw_e;

	// register fields
	logic [1:0] clock_source_selector_q;
	logic [1:0] osc_enable_field_q;
	logic [2:0] osc_divide_select_q;
	logic suspend_q;
	logic ready_q;

	// oscillator model
	logic [SCS_NCO_W-1:0] phase_q;
	logic [SCS_NCO_W-1:0] phase_step;
	logic [SCS_NCO_W:0] phase_sum;
	logic osc_on;
	logic osc_tick_q;
	logic int_div_tick;
	logic [SCS_SETTLE_W-1:0] settle_q;
	scs_trim_s trim_q;
	logic osc_on_q;

	// external oscillator edge
	logic ext_lvl;
	logic ext_lvl_q;
	logic ext_tick;

	// wake sources
	scs_wake_s wake_sync;
	logic wake_event;
	scs_susp_e susp_q;

	// source switching
	scs_sw_e sw_q;
	logic [1:0] active_q;
	logic [1:0] target_q;
	logic old_tick;
	logic old_dead;
	logic sel_tick;

	// write strobes
	logic wr_sel;
	logic wr_osc;

	assign wr_sel = sfr_req.wr && (sfr_req.addr == SCS_CLK_SEL_ADDR);
	assign wr_osc = sfr_req.wr && (sfr_req.addr == SCS_OSC_CTRL_ADDR);

	function automatic logic src_tick(input logic [1:0] src,
			input logic t_int, input logic t_ext, input logic t_mul);
		logic t;
		t = 1'b0;
		case (src)
			SCS_SRC_INT_OSC: t = t_int;
			SCS_SRC_EXT_OSC: t = t_ext;
			SCS_SRC_MULT: t = t_mul;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// register writes

	// only bits 1:0 are stored; upper bits do not exist
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			clock_source_selector_q <= SCS_SEL_RESET;
		end else if (wr_sel) begin
			clock_source_selector_q <=
				sfr_req.wdata[SCS_SEL_MSB:SCS_SEL_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			osc_enable_field_q <= SCS_EN_RESET;
			osc_divide_select_q <= SCS_DIV_RESET;
		end else if (wr_osc) begin
			osc_enable_field_q <= sfr_req.wdata[SCS_EN_MSB:SCS_EN_LSB];
			osc_divide_select_q <= sfr_req.wdata[SCS_DIV_MSB:SCS_DIV_LSB];
		end
	end

	// suspend and wake

	scs_sync #(
		.WIDTH($bits(scs_wake_s))
	) u_wake_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(wake_in),
		.sync_out(wake_sync)
	);

	// any port match, or comparator 0 enabled and driving low
	assign wake_event = (|wake_sync.port_match) ||
		(wake_sync.cmp0_enable && !wake_sync.cmp0_out);

	// a wake that meets the suspend write wins, so no event is lost
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			susp_q <= ST_RUN;
			suspend_q <= SCS_SUSP_RESET;
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= 1'b0;
			case (susp_q)
				ST_RUN: begin
					if (wr_osc && sfr_req.wdata[SCS_SUSP_BIT] &&
							!wake_event) begin
						susp_q <= ST_SUSPEND;
						suspend_q <= 1'b1;
					end
				end
				ST_SUSPEND: begin
					if (wake_event) begin
						susp_q <= ST_WAKE;
						suspend_q <= 1'b0;
					end
				end
				// pulse lands with the suspended flag dropping
				ST_WAKE: begin
					susp_q <= ST_RUN;
					wake_pulse <= 1'b1;
				end
				default: begin
					susp_q <= ST_RUN;
					suspend_q <= 1'b0;
				end
			endcase
		end
	end

	// internal oscillator

	// reserved enable codes leave the oscillator stopped
	assign osc_on = (osc_enable_field_q == SCS_EN_ON) && !suspend_q;

	// coarse trim weighs 64 fine steps; mid trim gives about 31 MHz
	assign phase_step = {1'b0, osc_trim.coarse, osc_trim.fine,
		2'h0};
	assign phase_sum = {1'b0, phase_q} + {1'b0, phase_step};

	// oscillator halts with its phase held, so a restart is clean
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			phase_q <= '0;
			osc_tick_q <= 1'b0;
		end else if (osc_on) begin
			phase_q <= phase_sum[SCS_NCO_W-1:0];
			osc_tick_q <= phase_sum[SCS_NCO_W];
		end else begin
			osc_tick_q <= 1'b0;
		end
	end

	scs_div #(
		.CODE_W(3)
	) u_div (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.osc_tick(osc_tick_q),
		.osc_divide_select(osc_divide_select_q),
		.div_tick(int_div_tick)
	);

	// ready drops on stop, start or retrim, rises after settling
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			trim_q <= osc_trim; // else reset looks like a retrim
			osc_on_q <= 1'b1;
			settle_q <= '0;
			ready_q <= SCS_RDY_RESET;
		end else begin
			trim_q <= osc_trim;
			osc_on_q <= osc_on;
			if (!osc_on) begin
				ready_q <= 1'b0;
				settle_q <= '0;
			end else if (!osc_on_q || (trim_q != osc_trim)) begin
				ready_q <= 1'b0;
				settle_q <= '0;
			end else if (!ready_q) begin
				if (settle_q == SCS_SETTLE_W'(SETTLE_CYC - 1)) begin
					ready_q <= 1'b1;
				end else begin
					settle_q <= settle_q + 1'b1;
				end
			end
		end
	end

	// external oscillator

	scs_sync #(
		.WIDTH(1)
	) u_ext_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(ext_osc_clk),
		.sync_out(ext_lvl)
	);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ext_lvl_q <= 1'b0;
		end else begin
			ext_lvl_q <= ext_lvl;
		end
	end

	assign ext_tick = ext_lvl && !ext_lvl_q;

	// source handover

	assign old_tick = src_tick(active_q, int_div_tick, ext_tick, mult_tick);
	// a stopped internal oscillator never ticks, so do not wait for it
	assign old_dead = (active_q == SCS_SRC_INT_OSC) && !osc_on;

	// reserved code 11 is never adopted; the old source stays
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sw_q <= SW_IDLE;
			active_q <= SCS_SEL_RESET;
			target_q <= SCS_SEL_RESET;
		end else begin
			case (sw_q)
				SW_IDLE: begin
					if (clock_source_selector_q != active_q &&
							clock_source_selector_q != SCS_SRC_RSVD) begin
						target_q <= clock_source_selector_q;
						sw_q <= SW_DRAIN;
					end
				end
				SW_DRAIN: begin
					// change just after an old pulse ends, or at once from a stopped internal oscillator
					if (old_tick || old_dead) begin
						active_q <= target_q;
						sw_q <= SW_IDLE;
					end
				end
				default: begin
					sw_q <= SW_IDLE;
				end
			endcase
		end
	end

	// block every pulse, old source included, while the handover drains
	assign sel_tick = (sw_q == SW_DRAIN) ? 1'b0 :
		src_tick(active_q, int_div_tick, ext_tick, mult_tick);

	// outputs

	// gating only stalls pulses, so the core resumes where it stopped
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			system_clock_out <= 1'b0;
			cpu_clk_en <= 1'b0;
		end else begin
			system_clock_out <= sel_tick;
			cpu_clk_en <= sel_tick &&
				!(suspend_q && active_q == SCS_SRC_INT_OSC);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			osc_running <= 1'b1;
			osc_freq_ready_flag <= SCS_RDY_RESET;
			osc_suspended <= SCS_SUSP_RESET;
			clock_source_active <= SCS_SEL_RESET;
		end else begin
			osc_running <= osc_on;
			osc_freq_ready_flag <= ready_q;
			osc_suspended <= suspend_q;
			clock_source_active <= active_q;
		end
	end

	// register reads

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sfr_rdata <= SCS_RD_ZERO;
		end else if (sfr_req.rd) begin
			sfr_rdata <= SCS_RD_ZERO;
			if (sfr_req.addr == SCS_CLK_SEL_ADDR) begin
				sfr_rdata[SCS_SEL_MSB:SCS_SEL_LSB] <=
					clock_source_selector_q;
			end else if (sfr_req.addr == SCS_OSC_CTRL_ADDR) begin
				sfr_rdata[SCS_EN_MSB:SCS_EN_LSB] <= osc_enable_field_q;
				sfr_rdata[SCS_SUSP_BIT] <= suspend_q;
				sfr_rdata[SCS_RDY_BIT] <= ready_q;
				sfr_rdata[SCS_RSVD_BIT] <= 1'b0;
				sfr_rdata[SCS_DIV_MSB:SCS_DIV_LSB] <= osc_divide_select_q;
			end
		end
	end

endmodule
`default_nettype wire

// ### tb/scs_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module scs_ctrl_chk
	import scs_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic nrst, // sync reset, active low
	input wire scs_sfr_req_s sfr_req, // register request
	input wire logic [7:0] sfr_rdata, // read data
	input wire logic mult_tick, // multiplier pulse
	input wire scs_wake_s wake_in, // wake levels
	input wire logic system_clock_out, // clock pulse
	input wire logic cpu_clk_en, // gated clock pulse
	input wire logic osc_running, // oscillator on
	input wire logic osc_freq_ready_flag, // settled
	input wire logic osc_suspended, // suspend in force
	input wire logic wake_pulse, // wake seen
	input wire logic [1:0] clock_source_active // source in use
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic wake_ev;
	// async levels; the sync delay is covered by the window below
	assign wake_ev = (|wake_in.port_match) ||
		(wake_in.cmp0_enable && !wake_in.cmp0_out);
	sel_hi_a: assert property (sfr_req.rd && sfr_req.addr == 8'h8F
		|=> sfr_rdata[7:2] == 6'h00) else $error("select upper bits set");
	rsvd_bit_a: assert property (sfr_req.rd && sfr_req.addr == 8'hA1
		|=> !sfr_rdata[3]) else $error("reserved bit reads one");
	rst_state_a: assert property ($rose(nrst) |->
		clock_source_active == 2'h0 && !osc_suspended && osc_freq_ready_flag)
		else $error("wrong state after reset");
	src_rsvd_a: assert property (clock_source_active != 2'h3)
		else $error("reserved source active");
	mult_src_a: assert property (clock_source_active == 2'h2 &&
		system_clock_out |-> $past(mult_tick)) else $error("stray pulse");
	susp_stop_a: assert property (osc_suspended |-> !osc_running)
		else $error("oscillator runs in suspend");
	cpu_gate_a: assert property (osc_suspended &&
		clock_source_active == 2'h0 |-> !cpu_clk_en)
		else $error("processor clock not gated");
	wake_ev_a: assert property (osc_suspended && wake_ev
		|-> ##[1:6] wake_pulse) else $error("wake event missed");
	wake_end_a: assert property (wake_pulse |-> !osc_suspended)
		else $error("suspend kept after wake");
	rdy_off_a: assert property (!osc_running [*3]
		|-> !osc_freq_ready_flag) else $error("ready while stopped");
	rdy_start_a: assert property ($rose(osc_running)
		|=> !osc_freq_ready_flag [*2]) else $error("ready too early");
	cover property (wake_pulse);
	cover property (clock_source_active == 2'h1 && system_clock_out);
	cover property (clock_source_active == 2'h2 && system_clock_out);
endmodule
bind scs_ctrl scs_ctrl_chk scs_ctrl_chk_i (.sys_clk(sys_clk), .nrst(nrst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mult_tick(mult_tick),
	.wake_in(wake_in), .system_clock_out(system_clock_out),
	.cpu_clk_en(cpu_clk_en), .osc_running(osc_running),
	.osc_freq_ready_flag(osc_freq_ready_flag),
	.osc_suspended(osc_suspended), .wake_pulse(wake_pulse),
	.clock_source_active(clock_source_active));
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import scs_pkg::*;
;
	logic sys_clk = 0;
	logic nrst = 0;
	scs_sfr_req_s sfr_req = '0;
	scs_trim_s osc_trim = {7'h40, 6'h00};
	scs_wake_s wake_in = {4'h0, 1'b0, 1'b1};
	logic ext_osc_clk = 0;
	logic mult_tick = 0;
	logic [7:0] sfr_rdata;
	logic system_clock_out;
	logic wake_pulse;
	logic rd_seen = 0;
	logic [7:0] rnd = 8'h15;
	logic [7:0] rq[$];
	int pq[$];
	int err_total = 0;
	int checks_done = 0;
	int gap = 0;
	int arm = 0;
	int ecnt = 0;

	scs_ctrl #(.SETTLE_CYC(4)) scs_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .osc_trim(osc_trim),
		.ext_osc_clk(ext_osc_clk), .mult_tick(mult_tick), .wake_in(wake_in),
		.system_clock_out(system_clock_out), .cpu_clk_en(),
		.osc_running(), .osc_freq_ready_flag(), .osc_suspended(),
		.wake_pulse(wake_pulse), .clock_source_active());

	always #4 sys_clk = ~sys_clk;

	// external period 10 cycles, multiplier pulse every 3
	always @(posedge sys_clk) begin
		ecnt <= (ecnt == 29) ? 0 : ecnt + 1;
		ext_osc_clk <= (ecnt % 10) < 5;
		mult_tick <= (ecnt % 3) == 0;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkp(string n, int e, int g);
		checks_done++;
		if (g != e) begin
			err_total++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask

	always @(posedge sys_clk) begin
		if (rd_seen) chk8("sfr_rdata", rq.pop_front(), sfr_rdata);
		rd_seen <= sfr_req.rd;
		gap <= (system_clock_out === 1'b1) ? 1 : gap + 1;
		if (system_clock_out === 1'b1 && arm > 0) begin
			if (arm == 1) chkp("clock period", pq.pop_front(), gap);
			arm <= arm - 1;
		end
	end

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		sfr_req <= {a, d, 2'b10};
		@(posedge sys_clk);
		sfr_req <= '0;
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] e);
		rq.push_back(e);
		@(posedge sys_clk);
		sfr_req <= {a, 8'h00, 2'b01};
		@(posedge sys_clk);
		sfr_req <= '0;
	endtask

	// first three pulses skipped: divider and source switch settle there
	task automatic per(int e);
		int n;
		n = 0;
		pq.push_back(e);
		arm <= 4;
		@(posedge sys_clk);
		while (arm != 0 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		if (arm != 0) begin
			err_total++;
			$display("[FAIL] clock period expected %0d seen none", e);
			arm <= 0;
			void'(pq.pop_front());
		end
	endtask

	task automatic waitw;
		int n;
		n = 0;
		while (wake_pulse !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		chk8("wake_pulse", 8'h01, {7'h00, wake_pulse});
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#400000;
		err_total++;
		test_done;
	end

	initial begin
		cyc(3);
		nrst <= 1'b1;
		rd(8'h8F, 8'h00);
		rd(8'hA1, 8'hD0);
		rd(8'h55, 8'h00);
		$display("reset values done");
		for (int c = 0; c < 8; c++) begin
			wr(8'hA1, 8'hC0 | 8'(c));
			per(4 << (7 - c));
		end
		$display("divider done");
		wr(8'hA1, 8'hD7);
		cyc(8);
		rd(8'hA1, 8'hD7);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr(8'h8F, {rnd[7:2], 2'b00});
			rd(8'h8F, 8'h00);
		end
		$display("reserved bits done");
		wr(8'h8F, 8'h01);
		per(10);
		wr(8'h8F, 8'h02);
		per(3);
		wr(8'h8F, 8'h03);
		rd(8'h8F, 8'h03);
		per(3);
		wr(8'h8F, 8'h00);
		per(4);
		$display("source switch done");
		wr(8'hA1, 8'hE7);
		cyc(4);
		rd(8'hA1, 8'hE7);
		wake_in.port_match <= 4'h4;
		waitw;
		wake_in.port_match <= 4'h0;
		cyc(10);
		rd(8'hA1, 8'hD7);
		wr(8'hA1, 8'hE7);
		wake_in.cmp0_enable <= 1'b1;
		cyc(10);
		rd(8'hA1, 8'hE7);
		wake_in.cmp0_out <= 1'b0;
		waitw;
		wake_in <= {4'h0, 1'b0, 1'b1};
		cyc(10);
		rd(8'hA1, 8'hD7);
		per(4);
		$display("suspend done");
		wr(8'hA1, 8'h07);
		cyc(4);
		rd(8'hA1, 8'h07);
		wr(8'hA1, 8'hC7);
		cyc(10);
		rd(8'hA1, 8'hD7);
		cyc(3);
		$display("enable done");
		test_done;
	end
endmodule
`default_nettype wire
